// file: inc/tof_readout_consts.svh
// Purpose: offsets, field positions, reset values and geometry constants
// Assumes: included by bare name from the readout design
// Notes: the list below summarises the readout behaviour
//
// Overview of operation
// - each pixel: A minus B as signed 12-bit sample plus saturation flag
// - saturation flag leaves on its own pin together with the pixel sample
// - flag pin reassigned and force bit set: saturated samples read 0xFFF
// - one coordinate system: columns 4 to 323, rows 6 to 245
// - top and bottom halves read in parallel, from the middle outward
// - rows convert evens then odds but leave in natural column order
// - same-position pixels of all 2x2 groups are driven together
// - full resolution drives all positions alike; 1, 2 or 4 frames
// - dual phase: odd rows run a quarter period after even rows
// - dual integration: even rows use length 1, odd rows length 2
// - either integration length may be the longer one
// - horizontal, vertical or both binning before conversion
// - every second column, and every second, fourth or eighth row
// - reduction combines with binning and both dual modes
// - frame time follows rows read; output time follows columns read
// - frames step the gate phase by a quarter period, first at 0
`ifndef TOF_READOUT_CONSTS_SVH
`define TOF_READOUT_CONSTS_SVH
`define REG_RED_BIN     8'h94
`define REG_ILEN2_HI    8'h9E
`define REG_ILEN2_LO    8'h9F
`define REG_ILEN1_HI    8'hA2
`define REG_ILEN1_LO    8'hA3
`define REG_FLAG_CFG    8'hCC
`define RB_COL_RED      0
`define RB_ROW_RED_LSB  1
`define RB_BIN_H        3
`define RB_BIN_V        4
`define FC_ALT_FUNC     6
`define FC_FORCE_ONES   7
`define RST_RED_BIN     8'h00
`define RST_FLAG_CFG    8'h00
`define RST_ILEN        16'h0040
`define ROW_FIRST       8'h06
`define ROW_LAST        8'hF5
`define ROW_MID_TOP     8'h7D
`define ROW_MID_BOT     8'h7E
`define HALF_ROWS       7'h78
`define SAMPLE_POS_MAX  12'h7FF
`define SAMPLE_NEG_MIN  12'h800
`define SAMPLE_ONES     12'hFFF
`define CHARGE_FULL     12'hFFF
`endif

// file: inc/tof_readout_pkg.sv
// Purpose: types of the pixel readout block
// Assumes: constants come from the consts header
// Notes: one packed struct carries every flip-flop except the row buffer
package tof_readout_pkg;
  typedef enum logic [2:0] {
    IDLE  = 3'h0,
    INTEG = 3'h1,
    CONV  = 3'h3,
    EMIT  = 3'h2,
    NEXT  = 3'h6
  } fsm_t;

  typedef struct packed {
    fsm_t        st;
    logic [7:0]  redBin;
    logic [15:0] ilen1;
    logic [15:0] ilen2;
    logic [7:0]  flagCfg;
    logic [2:0]  vclkSync;
    logic [2:0]  shutSync;
    logic [1:0]  modSync;
    logic [1:0]  quadSync;
    logic [1:0]  dcsIdx;
    logic [1:0]  dcsDone;
    logic [15:0] intCnt;
    logic [6:0]  rowIdx;
    logic        rowHalf;
    logic [7:0]  evenCnt;
    logic [7:0]  oddCnt;
    logic [8:0]  outIdx;
    logic [11:0] data;
    logic        sat;
    logic        hsync;
    logic        vsync;
    logic [1:0]  gate0;
    logic [1:0]  gate1;
    logic [7:0]  topRow;
    logic [7:0]  botRow;
    logic        convReq;
    logic [7:0]  rdData;
  } state_t;
endpackage

// file: src/tof_pixel_readout.sv
// Purpose: readout modes, row order, sample forming and video output
// Assumes: converter and register port share core_clk; pins are async
// Notes: one row buffer; converter waits while a row is being sent
`timescale 1ns/1ps
`include "tof_readout_consts.svh"
module tof_pixel_readout #(
  parameter int COLS = 320
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // register port
  input  wire logic        regWrEn,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  output logic      [7:0]  regRdData,
  // mode selection
  input  wire logic        dualPhaseMode,
  input  wire logic        dualIntegMode,
  input  wire logic [1:0]  dcsCount,
  // pins from outside the clock domain
  input  wire logic        shutterPin,
  input  wire logic        modClkPin,
  input  wire logic        modQuadPin,
  input  wire logic        videoClkPin,
  // converter results
  input  wire logic        adcValid,
  input  wire logic        adcOdd,
  input  wire logic [11:0] adcChargeA,
  input  wire logic [11:0] adcChargeB,
  input  wire logic        adcRowDone,
  // pixel field control
  output logic      [1:0]  rowGroupGate0,
  output logic      [1:0]  rowGroupGate1,
  output logic      [1:0]  binCtrl,
  output logic      [7:0]  topRow,
  output logic      [7:0]  botRow,
  output logic             rowConvReq,
  // parallel video output
  output logic      [11:0] videoData,
  output logic             satFlagPin,
  output logic             hsyncPin,
  output logic             vsyncPin
);

  localparam tof_readout_pkg::state_t RST = '{
    st:      tof_readout_pkg::IDLE,
    redBin:  `RST_RED_BIN,
    ilen1:   `RST_ILEN,
    ilen2:   `RST_ILEN,
    flagCfg: `RST_FLAG_CFG,
    default: '0
  };

  tof_readout_pkg::state_t q_reg, q_next;
  logic [12:0] rowMem [COLS];
  logic        memWe;
  logic [8:0]  memAddr;
  logic [12:0] memIn;
  logic [12:0] memQ;
  logic        vEdge, shutEdge, colRed, altFunc, forceOnes;
  logic [6:0]  rowStep;
  logic [8:0]  lim, outStep;
  logic [15:0] maxLen;
  logic [1:0]  frameLast;
  logic        en0, en1;
  logic [12:0] diff;
  logic [11:0] sample;
  logic        satNow;

  // gate pair for a quarter-period phase step
  function automatic logic [1:0] gateOf(input logic [1:0] p,
                                        input logic m,
                                        input logic qd);
    logic [1:0] g;
    g = 2'h0;
    case (p)
      2'h0: g = {m, ~m};
      2'h1: g = {qd, ~qd};
      2'h2: g = {~m, m};
      default: g = {~qd, qd};
    endcase
    return g;
  endfunction

  // decoded settings and edges
  assign vEdge     = q_reg.vclkSync[1] & ~q_reg.vclkSync[2];
  assign shutEdge  = q_reg.shutSync[1] & ~q_reg.shutSync[2];
  assign colRed    = q_reg.redBin[`RB_COL_RED];
  assign altFunc   = q_reg.flagCfg[`FC_ALT_FUNC];
  assign forceOnes = q_reg.flagCfg[`FC_FORCE_ONES];
  assign rowStep   = 7'h01 << q_reg.redBin[`RB_ROW_RED_LSB +: 2];
  assign outStep   = colRed ? 9'h002 : 9'h001;
  assign lim       = {q_reg.evenCnt, 1'b0};
  assign memQ      = rowMem[q_reg.outIdx];
  assign frameLast = (dcsCount == 2'h0) ? 2'h0 :
                     (dcsCount == 2'h1) ? 2'h1 : 2'h3;
  // in dual integration the longer of the two lengths ends integration; otherwise length 1
  assign maxLen    = (dualIntegMode && q_reg.ilen2 > q_reg.ilen1) ?
                     q_reg.ilen2 : q_reg.ilen1;
  assign en0       = q_reg.intCnt < q_reg.ilen1;
  assign en1       = dualIntegMode ? (q_reg.intCnt < q_reg.ilen2) : en0;

  // signed difference of storage gate charges, clamped to 12 bits
  always_comb begin
    diff   = {1'b0, adcChargeA} - {1'b0, adcChargeB};
    sample = diff[11:0];
    satNow = (adcChargeA == `CHARGE_FULL) || (adcChargeB == `CHARGE_FULL);
    if (!diff[12] && diff[11]) begin
      sample = `SAMPLE_POS_MAX;
      satNow = 1'b1;
    end else if (diff[12] && !diff[11]) begin
      sample = `SAMPLE_NEG_MIN;
      satNow = 1'b1;
    end
  end

  // next state of the whole block
  always_comb begin
    q_next         = q_reg;
    q_next.convReq = 1'b0;
    memWe          = 1'b0;
    memAddr        = adcOdd ? {q_reg.oddCnt, 1'b1} : {q_reg.evenCnt, 1'b0};
    memIn          = {satNow, sample};
    q_next.vclkSync = {q_reg.vclkSync[1:0], videoClkPin};
    q_next.shutSync = {q_reg.shutSync[1:0], shutterPin};
    q_next.modSync  = {q_reg.modSync[0], modClkPin};
    q_next.quadSync = {q_reg.quadSync[0], modQuadPin};
    // register writes
    if (regWrEn) begin
      if (regAddr == `REG_RED_BIN) begin
        q_next.redBin = regWrData;
      end else if (regAddr == `REG_ILEN2_HI) begin
        q_next.ilen2[15:8] = regWrData;
      end else if (regAddr == `REG_ILEN2_LO) begin
        q_next.ilen2[7:0] = regWrData;
      end else if (regAddr == `REG_ILEN1_HI) begin
        q_next.ilen1[15:8] = regWrData;
      end else if (regAddr == `REG_ILEN1_LO) begin
        q_next.ilen1[7:0] = regWrData;
      end else if (regAddr == `REG_FLAG_CFG) begin
        q_next.flagCfg = regWrData;
      end
    end
    // register reads
    if (regAddr == `REG_RED_BIN) begin
      q_next.rdData = q_reg.redBin;
    end else if (regAddr == `REG_ILEN2_HI) begin
      q_next.rdData = q_reg.ilen2[15:8];
    end else if (regAddr == `REG_ILEN2_LO) begin
      q_next.rdData = q_reg.ilen2[7:0];
    end else if (regAddr == `REG_ILEN1_HI) begin
      q_next.rdData = q_reg.ilen1[15:8];
    end else if (regAddr == `REG_ILEN1_LO) begin
      q_next.rdData = q_reg.ilen1[7:0];
    end else if (regAddr == `REG_FLAG_CFG) begin
      q_next.flagCfg = q_next.flagCfg;
      q_next.rdData  = q_reg.flagCfg;
    end else begin
      q_next.rdData = 8'h00;
    end
    q_next.gate0 = 2'h0;
    q_next.gate1 = 2'h0;
    case (q_reg.st)
      tof_readout_pkg::IDLE: begin
        if (shutEdge) begin
          q_next.st     = tof_readout_pkg::INTEG;
          q_next.intCnt = 16'h0000;
          q_next.dcsIdx = 2'h0;
          q_next.dcsDone = 2'h0;
          q_next.rowIdx = 7'h00;
        end
      end
      tof_readout_pkg::INTEG: begin
        // all pixel groups share these two gate pairs
        if (en0) begin
          q_next.gate0 = gateOf(q_reg.dcsIdx, q_reg.modSync[1],
                                q_reg.quadSync[1]);
        end
        if (en1) begin
          q_next.gate1 = gateOf(dualPhaseMode ? 2'(q_reg.dcsIdx + 2'h1)
                                              : q_reg.dcsIdx,
                                q_reg.modSync[1], q_reg.quadSync[1]);
        end
        q_next.intCnt = q_reg.intCnt + 16'h0001;
        if (q_reg.intCnt >= maxLen) begin
          q_next.st      = tof_readout_pkg::CONV;
          q_next.convReq = 1'b1;
          q_next.rowHalf = 1'b0;
          q_next.evenCnt = 8'h00;
          q_next.oddCnt  = 8'h00;
          q_next.topRow  = `ROW_MID_TOP - {1'b0, q_reg.rowIdx};
          q_next.botRow  = `ROW_MID_BOT + {1'b0, q_reg.rowIdx};
        end
      end
      tof_readout_pkg::CONV: begin
        // evens land on even slots, odds on odd slots
        if (adcValid && memAddr < 9'(COLS)) begin
          memWe = 1'b1;
          if (adcOdd) begin
            q_next.oddCnt = q_reg.oddCnt + 8'h01;
          end else begin
            q_next.evenCnt = q_reg.evenCnt + 8'h01;
          end
        end
        if (adcRowDone) begin
          q_next.st     = tof_readout_pkg::EMIT;
          q_next.outIdx = 9'h000;
          q_next.vsync  = 1'b1;
        end
      end
      tof_readout_pkg::EMIT: begin
        // one pixel per data clock, natural column order
        if (vEdge) begin
          if (q_reg.outIdx < lim) begin
            q_next.data   = (memQ[12] && altFunc && forceOnes) ?
                            `SAMPLE_ONES : memQ[11:0];
            q_next.sat    = altFunc ? 1'b1 : memQ[12];
            q_next.hsync  = 1'b1;
            q_next.outIdx = q_reg.outIdx + outStep;
          end else begin
            q_next.hsync = 1'b0;
            q_next.sat   = altFunc ? 1'b0 : q_reg.sat;
            q_next.st    = tof_readout_pkg::NEXT;
          end
        end
      end
      default: begin
        q_next.evenCnt = 8'h00;
        q_next.oddCnt  = 8'h00;
        q_next.st      = tof_readout_pkg::CONV;
        if (!q_reg.rowHalf) begin
          q_next.rowHalf = 1'b1;
          q_next.convReq = 1'b1;
        end else if (q_reg.rowIdx + rowStep >= `HALF_ROWS) begin
          // frame done; fewer rows read means a shorter frame
          q_next.vsync   = 1'b0;
          q_next.rowIdx  = 7'h00;
          q_next.dcsDone = q_reg.dcsDone + 2'h1;
          q_next.dcsIdx  = q_reg.dcsIdx + 2'h1;
          q_next.intCnt  = 16'h0000;
          q_next.st      = (q_reg.dcsDone == frameLast) ?
                           tof_readout_pkg::IDLE : tof_readout_pkg::INTEG;
        end else begin
          q_next.rowIdx  = q_reg.rowIdx + rowStep;
          q_next.rowHalf = 1'b0;
          q_next.convReq = 1'b1;
          q_next.topRow  = `ROW_MID_TOP - {1'b0, 7'(q_reg.rowIdx + rowStep)};
          q_next.botRow  = `ROW_MID_BOT + {1'b0, 7'(q_reg.rowIdx + rowStep)};
        end
      end
    endcase
  end

  // state registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      q_reg <= RST;
    end else begin
      q_reg <= q_next;
    end
  end

  // row buffer, contents need no reset
  always_ff @(posedge core_clk) begin
    if (memWe) begin
      rowMem[memAddr] <= memIn;
    end
  end

  // outputs straight from flip-flops
  assign regRdData     = q_reg.rdData;
  assign rowGroupGate0 = q_reg.gate0;
  assign rowGroupGate1 = q_reg.gate1;
  assign binCtrl       = {q_reg.redBin[`RB_BIN_V],
                          q_reg.redBin[`RB_BIN_H]};
  assign topRow        = q_reg.topRow;
  assign botRow        = q_reg.botRow;
  assign rowConvReq    = q_reg.convReq;
  assign videoData     = q_reg.data;
  assign satFlagPin    = q_reg.sat;
  assign hsyncPin      = q_reg.hsync;
  assign vsyncPin      = q_reg.vsync;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  logic pixGo;
  assign pixGo = q_reg.st == tof_readout_pkg::EMIT && vEdge &&
                 q_reg.outIdx < lim;

  sat_force_a: assert property (pixGo && memQ[12] && altFunc
    && forceOnes |=> videoData == 12'hFFF)
    else $error("saturated pixel not forced");
  sat_pin_a: assert property (pixGo && !altFunc
    |=> satFlagPin == $past(memQ[12]) && hsyncPin)
    else $error("flag not with its sample");
  same_gate_a: assert property (!dualPhaseMode && !dualIntegMode
    && q_reg.st == tof_readout_pkg::INTEG |=> rowGroupGate0 == rowGroupGate1)
    else $error("full mode gates differ");
  odd_stop_a: assert property (q_reg.st == tof_readout_pkg::INTEG
    && dualIntegMode && q_reg.intCnt >= q_reg.ilen2 |=> rowGroupGate1 == 2'h0)
    else $error("odd rows still integrating");
  even_stop_a: assert property (q_reg.st == tof_readout_pkg::INTEG
    && q_reg.intCnt >= q_reg.ilen1 |=> rowGroupGate0 == 2'h0)
    else $error("even rows still integrating");
  row_mirror_a: assert property (rowConvReq
    |-> 9'(topRow) + 9'(botRow) == 9'h0FB) else $error("halves not mirrored");
  row_range_a: assert property (rowConvReq
    |-> topRow >= 8'h06 && botRow <= 8'hF5) else $error("row out of field");
  pix_step_a: assert property (pixGo
    |=> q_reg.outIdx == $past(q_reg.outIdx) + (colRed ? 9'h002 : 9'h001))
    else $error("column step wrong");
  integ_end_a: assert property (q_reg.st == tof_readout_pkg::INTEG
    && q_reg.intCnt >= maxLen |=> rowConvReq ##0 !vsyncPin[*1])
    else $error("integration did not end");

  start_c: cover property (shutEdge && q_reg.st == tof_readout_pkg::IDLE);
  frame_c: cover property ($fell(vsyncPin));
  forced_c: cover property (pixGo && memQ[12] && forceOnes && altFunc);
  dual_c: cover property (q_reg.st == tof_readout_pkg::INTEG && dualPhaseMode);
endmodule

// file: verif/testbench.sv
// Purpose: self-checking bench of the pixel readout block
// Assumes: a local model answers the converter; dcsCount sets frame count
// Notes: row reduction by eight keeps each frame short
`timescale 1ns/1ps
`include "tof_readout_consts.svh"
module testbench;
  logic        core_clk, reset_n, regWrEn, dualPhaseMode, dualIntegMode;
  logic        shutterPin, modClkPin, modQuadPin, videoClkPin, run;
  logic        adcValid, adcOdd, adcRowDone, rowConvReq;
  logic        satFlagPin, hsyncPin, vsyncPin;
  logic [1:0]  dcsCount, rowGroupGate0, rowGroupGate1, binCtrl;
  logic [7:0]  regAddr, regWrData, regRdData, topRow, botRow;
  logic [11:0] adcChargeA, adcChargeB, videoData;
  logic [15:0] rowsQ[$];
  logic [2:0]  mH, qH;
  logic [1:0]  expPh, expG;
  int          error_cnt, n_compared, g0Cnt, g1Cnt, gDiff, phMiss;

  tof_pixel_readout i_dut (
    .core_clk, .reset_n, .regWrEn, .regAddr, .regWrData, .regRdData,
    .dualPhaseMode, .dualIntegMode, .dcsCount, .shutterPin, .modClkPin,
    .modQuadPin, .videoClkPin, .adcValid, .adcOdd, .adcChargeA,
    .adcChargeB, .adcRowDone, .rowGroupGate0, .rowGroupGate1, .binCtrl,
    .topRow, .botRow, .rowConvReq, .videoData, .satFlagPin, .hsyncPin,
    .vsyncPin
  );

  video_grabber i_grab (
    .run, .videoClk(videoClkPin), .videoData, .satFlag(satFlagPin),
    .hsync(hsyncPin)
  );

  // system clock and modulation pair a quarter period apart
  always #5 core_clk = ~core_clk;
  always #20 modClkPin = ~modClkPin;
  initial #10 forever #20 modQuadPin = ~modQuadPin;

  // active cycles of each row-group gate and cycles where they differ
  always @(posedge core_clk) begin
    if (rowGroupGate0 !== 2'b00) g0Cnt++;
    if (rowGroupGate1 !== 2'b00) g1Cnt++;
    if (rowGroupGate0 !== rowGroupGate1) gDiff++;
    if (rowGroupGate0 !== 2'b00 && rowGroupGate0 !== expG) phMiss++;
    mH <= {mH[1:0], modClkPin};
    qH <= {qH[1:0], modQuadPin};
  end

  // even-row gate pair due for the frame's quarter-period step
  assign expG = expPh[0] ? {qH[2] ^ expPh[1], ~qH[2] ^ expPh[1]}
                         : {mH[2] ^ expPh[1], ~mH[2] ^ expPh[1]};

  // converter model: four even samples, four odd, then row done
  always @(posedge core_clk) begin
    if (rowConvReq === 1'b1) begin
      rowsQ.push_back({topRow, botRow});
      for (int k = 0; k < 8; k++) begin
        adcOdd     <= (k > 3);
        adcChargeA <= (k > 3) ? 12'h200
                    : (k == 2) ? `CHARGE_FULL : 12'h200 + 12'(k);
        adcChargeB <= (k > 3) ? 12'h1FD + 12'(k)
                    : (k == 2) ? 12'h000 : 12'h200;
        adcValid   <= 1'b1;
        @(posedge core_clk);
        adcValid <= 1'b0;
        @(posedge core_clk);
      end
      adcRowDone <= 1'b1;
      @(posedge core_clk);
      adcRowDone <= 1'b0;
    end
  end

  task automatic chk(input logic [15:0] got, exp, input string what);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic stop_test;
    if (error_cnt == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge core_clk);
    regWrEn   <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWrEn <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, exp);
    @(posedge core_clk);
    regAddr <= a;
    repeat (2) @(posedge core_clk);
    #1 chk({8'h00, regRdData}, {8'h00, exp}, "register");
  endtask

  // column c of the model row: even c from even half, odd from odd half
  function automatic logic [15:0] expPix(input int c, input logic alt);
    logic [11:0] s;
    logic        sat;
    sat = (c == 4);
    s = (c % 2 == 0) ? 12'(c / 2) : 12'h000 - 12'(c / 2) - 12'h001;
    if (sat)
      s = alt ? `SAMPLE_ONES : `SAMPLE_POS_MAX;
    return {3'h0, alt | sat, s};
  endfunction

  task automatic wait_vsync(input logic lvl, input int lim);
    for (int t = 0; t < lim && vsyncPin !== lvl; t++)
      @(posedge core_clk);
    #1 chk(16'(vsyncPin), 16'(lvl), "vsync level");
  endtask

  task automatic frame(input logic [7:0] red, cfg, input logic ph, ig,
                       input logic [15:0] l1, l2);
    int          n;
    int          c;
    int          nf;
    logic [7:0]  st;
    logic [15:0] e;
    n = red[0] ? 4 : 8;
    st = 8'h01 << red[2:1];
    wr(`REG_RED_BIN, red);
    wr(`REG_FLAG_CFG, cfg);
    wr(`REG_ILEN1_HI, l1[15:8]);
    wr(`REG_ILEN1_LO, l1[7:0]);
    wr(`REG_ILEN2_HI, l2[15:8]);
    wr(`REG_ILEN2_LO, l2[7:0]);
    rowsQ.delete();
    i_grab.words.delete();
    {g0Cnt, g1Cnt, gDiff, phMiss} = '0;
    nf = (dcsCount == 2'h0) ? 1 : (dcsCount == 2'h1) ? 2 : 4;
    expPh = 2'h0;
    @(posedge core_clk);
    dualPhaseMode <= ph;
    dualIntegMode <= ig;
    run           <= 1'b1;
    shutterPin    <= 1'b1;
    repeat (5) @(posedge core_clk);
    shutterPin <= 1'b0;
    // each frame of one shutter advances the gate phase a quarter
    for (int f = 0; f < nf; f++) begin
      expPh = 2'(f);
      wait_vsync(1'b1, 5000);
      wait_vsync(1'b0, 30000);
    end
    run <= 1'b0;
    e = 16'(nf * 2 * (`HALF_ROWS >> red[2:1]));
    chk(16'(rowsQ.size()), e, "row requests");
    foreach (rowsQ[i]) begin
      c = (i / 2) % (`HALF_ROWS >> red[2:1]);
      e = {`ROW_MID_TOP - 8'(c) * st, `ROW_MID_BOT + 8'(c) * st};
      chk(rowsQ[i], e, "row pair");
    end
    e = 16'(rowsQ.size() * n);
    chk(16'(i_grab.words.size()), e, "pixel count");
    foreach (i_grab.words[i]) begin
      c = red[0] ? 2 * (i % 4) : i % 8;
      chk(i_grab.words[i], expPix(c, cfg[6]), "pixel");
    end
    chk(16'(phMiss), 16'h0000, "gate phase");
  endtask

  // reset, registers, then four frames in the different gate modes
  initial begin
    logic [7:0] ra[7];
    logic [7:0] rv[7];
    ra = '{`REG_RED_BIN, `REG_ILEN2_HI, `REG_ILEN2_LO, `REG_ILEN1_HI,
           `REG_ILEN1_LO, `REG_FLAG_CFG, 8'h95};
    rv = '{`RST_RED_BIN, 8'(`RST_ILEN >> 8), 8'(`RST_ILEN),
           8'(`RST_ILEN >> 8), 8'(`RST_ILEN), `RST_FLAG_CFG, 8'h00};
    {core_clk, reset_n, regWrEn, dualPhaseMode, dualIntegMode} = '0;
    {shutterPin, modClkPin, modQuadPin, run, adcValid, adcOdd} = '0;
    {adcRowDone, dcsCount, regAddr, regWrData} = '0;
    {adcChargeA, adcChargeB} = '0;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    foreach (ra[i])
      rdc(ra[i], rv[i]);
    foreach (ra[i])
      wr(ra[i], 8'h1F);
    foreach (ra[i])
      rdc(ra[i], (i == 6) ? 8'h00 : 8'h1F);
    chk(16'(binCtrl), 16'h0003, "both binnings");
    wr(`REG_RED_BIN, 8'h0B);
    #1 chk(16'(binCtrl), 16'h0001, "horizontal binning");
    frame(8'h06, 8'h00, 1'b0, 1'b0, `RST_ILEN, `RST_ILEN);
    chk(16'(gDiff == 0 && g0Cnt > 0), 16'h0001, "same gates");
    frame(8'h07, 8'hC0, 1'b1, 1'b0, `RST_ILEN, `RST_ILEN);
    chk(16'(gDiff > 0), 16'h0001, "phase offset");
    frame(8'h06, 8'h00, 1'b0, 1'b1, 16'h0010, 16'h0030);
    chk(16'(g0Cnt < g1Cnt), 16'h0001, "even rows stop first");
    frame(8'h06, 8'h00, 1'b0, 1'b1, 16'h0030, 16'h0010);
    chk(16'(g0Cnt > g1Cnt), 16'h0001, "odd rows stop first");
    // four frames per shutter, one phase step each
    @(posedge core_clk);
    dcsCount <= 2'h2;
    frame(8'h07, 8'h00, 1'b0, 1'b0, `RST_ILEN, `RST_ILEN);
    stop_test();
  end

  // hang guard, far beyond four reduced frames
  initial begin
    #800000;
    error_cnt++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    stop_test();
  end
endmodule

// file: verif/video_grabber.sv
// Purpose: frame grabber model on the parallel video output
// Assumes: outputs settle well before the falling data-clock edge
// Notes: the data clock stands still while run is low
`timescale 1ns/1ps
module video_grabber (
  // control
  input  wire logic        run,
  // video link
  output logic             videoClk,
  input  wire logic [11:0] videoData,
  input  wire logic        satFlag,
  input  wire logic        hsync
);
  logic [15:0] words[$];
  // data clock, 160 ns period, only within frames
  initial videoClk = 1'b0;
  always #80 videoClk = run ? ~videoClk : 1'b0;
  // mid-cycle capture while a row streams, padded to a 16-bit word
  always @(negedge videoClk)
    if (hsync === 1'b1)
      words.push_back({3'h0, satFlag, videoData});
endmodule
